// file: logic/clk_ctrl_pkg.sv
// Package: register map, field layout and constants for the sample-clock control block
package clk_ctrl_pkg;

  // Register addresses on the configuration port
  localparam logic [7:0] clock_config_addr      = 8'h08;
  localparam logic [7:0] pll_control_addr       = 8'h0a;
  localparam logic [7:0] pll_loop_settings_addr = 8'h0c;
  localparam logic [7:0] pll_cross_control_addr = 8'h0d;
  localparam logic [7:0] vco_tuning_voltage_addr = 8'h0e;

  // Field positions
  localparam int loop_enable_bit   = 7;
  localparam int manual_band_bit   = 6;
  localparam int band_msb          = 5;
  localparam int cross_enable_bit  = 4;
  localparam int duty_correct_bit  = 7;
  localparam int level_correct_bit = 6;

  // Command value that launches automatic band calibration
  localparam logic [7:0] auto_cal_cmd = 8'h80;

  // Reset values
  localparam logic [7:0] clock_config_rst = 8'h00;
  localparam logic [7:0] pll_control_rst  = 8'h00;
  localparam logic [7:0] loop_settings_rst = 8'h00;
  localparam logic [7:0] cross_control_rst = 8'h00;

  // Band range and voltage-code thresholds
  localparam logic [5:0] band_count   = 6'h3f;  // 63 bands, codes 0..62
  localparam logic [5:0] band_first   = 6'h00;
  localparam logic [5:0] band_last    = 6'h3e;
  localparam logic [3:0] vtune_high_min = 4'he; // 1110..1111: move higher
  localparam logic [3:0] vtune_opt_max  = 4'h9; // 0110..1001: optimal
  localparam logic [3:0] vtune_opt_min  = 4'h6;
  localparam logic [3:0] vtune_low_max  = 4'h1; // 0000..0001: move lower

  // Settling time for each band step during calibration
  localparam int clk_hz        = 10_000_000;
  localparam int settle_us     = 10;
  localparam int settle_cycles = (settle_us * (clk_hz / 1_000_000) < 1) ? 1 : settle_us * (clk_hz / 1_000_000);

  // Indication of the voltage code
  typedef enum logic [2:0] {
    vt_move_lower = 3'b000,
    vt_lower_end  = 3'b001,
    vt_optimal    = 3'b010,
    vt_upper_end  = 3'b011,
    vt_move_higher = 3'b100
  } vtune_zone_t;

  // Configuration port access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

  // Analog-side control bundle
  typedef struct packed {
    logic       loop_enable;
    logic       use_direct_clock;
    logic [5:0] band;
    logic [2:0] loop_bw;
    logic [4:0] cp_current;
    logic       cross_enable;
    logic       duty_correct;
    logic       level_correct;
  } analog_ctrl_t;

endpackage

// file: logic/clock_source_ctrl.sv
// Sample-clock source selection, multiplier control and band calibration
//
// Operation
// R1 - Loop-enable 0 powers down multiplier; direct pins clock the converter
// R2 - Loop-enable 1 makes converter clock from reference through multiplier
// R3 - Oscillator = ref x both dividers; sample clock = ref x first divider
// R4 - Software keeps oscillator between 1.0 and 2.1 GHz with chosen dividers
// R5 - Oscillator range has 63 overlapping bands, chosen per device
// R6 - Writing 0x80 to loop control starts automatic band search
// R7 - Manual enable set: band comes straight from six-bit manual field
// R8 - Four-bit oscillator control voltage is readable
// R9 - Voltage codes map to move-higher, upper, optimal, lower, move-lower zones
// R10 - Software sweeps bands manually, picks mid-range voltage, writes it back
// R11 - Software sets loop bandwidth 110, charge pump 10001, cross enable 1
// R12 - Clock config register holds duty-cycle and level correction enables
// R13 - Multiplier lock is readable for manual calibration
//
// Notes
// The block runs on the control clock alone; the analog side owns the oscillator,
// the dividers, the clock receivers and the loop filter, and follows the bundle
// that this block registers. Every field of that bundle comes from a flop.
//
// Clock source
// With the loop enable bit clear the multiplier is powered down and the direct
// pins clock the converter. Setting it hands the sample clock to the multiplier.
// The frequency relations (oscillator = reference x both divider settings,
// sample clock = reference x first divider setting) live in the analog side;
// this block only selects the path and steers the oscillator band.
//
// Band search
// Writing the search command restarts the search at the lowest band. Each band
// is given settle_count cycles before the lock and the voltage code are judged.
// The search stops at the first band that is locked with the code in the optimal
// region, or holds the last band if none qualifies. Any other write to the loop
// control register aborts a running search, so software always wins.
// settle_count must cover the analog settling time plus three cycles: one for the
// band flop and two for the status synchronisers.
//
// Manual mode
// With the manual bit set the band comes from the register field and the search
// result is ignored. Software sweeps bands, reads lock and the voltage code, and
// writes back the band nearest mid-range.
//
// Status readback
// Bit 7 lock, bit 6 search idle, bit 5 search done, bit 4 code optimal,
// bits 3..0 the synchronised voltage code. The code is quasi-static, so its four
// bits cross through plain flops; a read taken while the code moves may mix two
// neighbouring codes, which software tolerates by reading again.
//
// Limitations
// Writes to the status register and to unmapped addresses are ignored;
// unmapped reads return zero. No interrupt is raised when the search ends.
`timescale 1ns/1ns
module clock_source_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter int settle_count = settle_cycles
) (
  input  wire logic         clk,          // 10 MHz control clock
  input  wire logic         rst,          // Synchronous reset, active high
  input  wire cfg_req_t     cfg_req,      // Configuration port access
  output logic [7:0]        cfg_rdata,    // Read data, one cycle after rd
  output logic              cfg_rvalid,   // Read data valid pulse
  input  wire logic [3:0]   vtune_code_in,  // Oscillator control voltage code, analog side
  input  wire logic         lock_in,      // Multiplier lock from analog side
  output analog_ctrl_t      analog_ctrl,  // Control bundle to the clock circuits
  output logic              cal_busy      // Automatic calibration running
);

  typedef enum logic [1:0] {
    cal_idle   = 2'b00,
    cal_settle = 2'b01,
    cal_judge  = 2'b10
  } cal_state_t;

  // Configuration registers and search state
  logic [7:0]  clock_config_r;   // Duty-cycle and level correction enables
  logic [7:0]  pll_control_r;    // Loop enable, manual enable, manual band
  logic [7:0]  loop_settings_r;  // Loop bandwidth and charge pump current
  logic [7:0]  cross_control_r;  // Cross control enable
  logic [5:0]  auto_band_r;      // Band chosen by the search
  logic        auto_valid_r;     // Search has finished
  cal_state_t  cal_state_r;      // Search state
  logic [15:0] settle_cnt_r;     // Cycles spent on the current band
  // Synchroniser stages
  logic [3:0]  vtune_s1_r;       // Voltage code, first stage
  logic [3:0]  vtune_s2_r;       // Voltage code, second stage
  logic        lock_s1_r;        // Lock, first stage
  logic        lock_s2_r;        // Lock, second stage
  // Decoded fields and read path
  logic        start_cal;        // Write of the search command
  logic        ctrl_wr;          // Any write to the loop control register
  logic        manual_mode;      // Manual band enable bit
  logic        loop_on;          // Loop enable bit
  logic [5:0]  band_sel;         // Band to hand to the oscillator
  logic [7:0]  status_word;      // Readback of the voltage register
  logic [7:0]  rd_mux;           // Read data before its register
  vtune_zone_t zone;             // Class of the voltage code
  // Analog control flops
  logic        loop_enable_r;    // Multiplier powered and selected
  logic        direct_clock_r;   // Direct pins selected
  logic [5:0]  band_r;           // Oscillator band
  logic [2:0]  loop_bw_r;        // Loop bandwidth
  logic [4:0]  cp_current_r;     // Charge pump current
  logic        cross_enable_r;   // Cross control enable
  logic        duty_correct_r;   // Duty-cycle correction enable
  logic        level_correct_r;  // Input-level correction enable

  // Voltage code synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      vtune_s1_r <= 4'h0;
      vtune_s2_r <= 4'h0;
    end else begin
      vtune_s1_r <= vtune_code_in;
      vtune_s2_r <= vtune_s1_r;
    end
  end

  // Lock synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      lock_s1_r <= lock_in;
      lock_s2_r <= lock_s1_r;
    end
  end

  // Classify the control voltage code
  always_comb begin
    if (vtune_s2_r >= vtune_high_min)        zone = vt_move_higher; // R9
    else if (vtune_s2_r > vtune_opt_max)     zone = vt_upper_end;   // R9
    else if (vtune_s2_r >= vtune_opt_min)    zone = vt_optimal;     // R9
    else if (vtune_s2_r > vtune_low_max)     zone = vt_lower_end;   // R9
    else                                     zone = vt_move_lower;  // R9
  end

  assign start_cal = cfg_req.wr && (cfg_req.addr == pll_control_addr) && (cfg_req.wdata == auto_cal_cmd); // R6

  // Decoded control fields
  assign ctrl_wr     = cfg_req.wr && (cfg_req.addr == pll_control_addr);
  assign manual_mode = pll_control_r[manual_band_bit]; // R7
  assign loop_on     = pll_control_r[loop_enable_bit]; // R1 R2
  assign band_sel    = manual_mode ? pll_control_r[band_msb:0] : auto_band_r; // R7 R5

  // Status word: lock, search idle, search done, optimal, voltage code
  assign status_word = {lock_s2_r, (cal_state_r == cal_idle), auto_valid_r, (zone == vt_optimal), vtune_s2_r}; // R8 R13

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_config_r  <= clock_config_rst;
      pll_control_r   <= pll_control_rst;
      loop_settings_r <= loop_settings_rst;
      cross_control_r <= cross_control_rst;
    end else if (cfg_req.wr) begin
      unique case (cfg_req.addr)
        clock_config_addr:      clock_config_r  <= cfg_req.wdata; // R12
        pll_control_addr:       pll_control_r   <= cfg_req.wdata; // R1 R2 R7
        pll_loop_settings_addr: loop_settings_r <= cfg_req.wdata;
        pll_cross_control_addr: cross_control_r <= cfg_req.wdata;
        default: ;
      endcase
    end
  end

  // Automatic band search: step bands from the lowest until the voltage is optimal and locked
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_state_r  <= cal_idle;
      auto_band_r  <= band_first;
      auto_valid_r <= 1'b0;
      settle_cnt_r <= 16'h0000;
    end else if (start_cal) begin
      cal_state_r  <= cal_settle; // R6
      auto_band_r  <= band_first;
      auto_valid_r <= 1'b0;
      settle_cnt_r <= 16'h0000;
    end else if (ctrl_wr) begin
      cal_state_r <= cal_idle;
    end else begin
      unique case (cal_state_r)
        cal_idle: ;
        // Wait for the analog side to follow the new band
        cal_settle: begin
          if (settle_cnt_r == 16'(settle_count - 1)) begin
            settle_cnt_r <= 16'h0000;
            cal_state_r  <= cal_judge;
          end else begin
            settle_cnt_r <= settle_cnt_r + 16'h0001;
          end
        end
        // Accept, give up at the last band, or step up
        cal_judge: begin
          if (lock_s2_r && zone == vt_optimal) begin
            auto_valid_r <= 1'b1; // R6
            cal_state_r  <= cal_idle;
          end else if (auto_band_r == band_last) begin
            auto_valid_r <= 1'b1; // Best effort: hold the last band
            cal_state_r  <= cal_idle;
          end else begin
            auto_band_r <= auto_band_r + 6'h01; // R5
            cal_state_r <= cal_settle;
          end
        end
        default: cal_state_r <= cal_idle;
      endcase
    end
  end

  // Clock source select: multiplier or direct pins
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_enable_r  <= 1'b0;
      direct_clock_r <= 1'b1;
    end else begin
      loop_enable_r  <= loop_on;  // R2 R3
      direct_clock_r <= ~loop_on; // R1
    end
  end

  // Oscillator band, manual field or search result
  always_ff @(posedge clk) begin
    if (rst) begin
      band_r <= 6'h00;
    end else begin
      band_r <= band_sel; // R7 R5
    end
  end

  // Loop filter settings
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_bw_r    <= 3'h0;
      cp_current_r <= 5'h00;
    end else begin
      loop_bw_r    <= loop_settings_r[7:5];
      cp_current_r <= loop_settings_r[4:0];
    end
  end

  // Cross control
  always_ff @(posedge clk) begin
    if (rst) begin
      cross_enable_r <= 1'b0;
    end else begin
      cross_enable_r <= cross_control_r[cross_enable_bit];
    end
  end

  // Clock input correction enables
  always_ff @(posedge clk) begin
    if (rst) begin
      duty_correct_r  <= 1'b0;
      level_correct_r <= 1'b0;
    end else begin
      duty_correct_r  <= clock_config_r[duty_correct_bit];  // R12
      level_correct_r <= clock_config_r[level_correct_bit]; // R12
    end
  end

  // Search busy flag, raised in the cycle after the command
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_busy <= 1'b0;
    end else begin
      cal_busy <= (cal_state_r != cal_idle) || start_cal; // R6
    end
  end

  // Bundle to the analog side, straight from the flops
  assign analog_ctrl = {loop_enable_r, direct_clock_r, band_r, loop_bw_r, cp_current_r,
                        cross_enable_r, duty_correct_r, level_correct_r};

  // Read mux
  always_comb begin
    unique case (cfg_req.addr)
      clock_config_addr:       rd_mux = clock_config_r;
      pll_control_addr:        rd_mux = pll_control_r;
      pll_loop_settings_addr:  rd_mux = loop_settings_r;
      pll_cross_control_addr:  rd_mux = cross_control_r;
      vco_tuning_voltage_addr: rd_mux = status_word; // R8 R13
      default:                 rd_mux = 8'h00;
    endcase
  end

  // Read valid pulse, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_req.rd) begin
      cfg_rdata <= rd_mux; // R8
    end
  end

endmodule

// file: sim/clock_source_ctrl_sva.sv
// Checker for the sample-clock control block
`timescale 1ns/1ns
module clock_source_ctrl_sva
  import clk_ctrl_pkg::*;
#(
  parameter int settle_count = 4
) (
  input wire logic         clk,           // Clock
  input wire logic         rst,           // Reset
  input wire cfg_req_t     cfg_req,       // Port access
  input wire logic [7:0]   cfg_rdata,     // Read data
  input wire logic         cfg_rvalid,    // Read valid
  input wire logic [3:0]   vtune_code_in, // Voltage code
  input wire logic         lock_in,       // Lock
  input wire analog_ctrl_t analog_ctrl,   // Controls
  input wire logic         cal_busy       // Search running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Write to the loop control register
  wire w_c = cfg_req.wr && cfg_req.addr == pll_control_addr;

  rd_answer_a: assert property (cfg_req.rd |=> cfg_rvalid)
    else $error("read not answered");
  src_sel_a: assert property (analog_ctrl.use_direct_clock == !analog_ctrl.loop_enable)
    else $error("source select wrong");
  loop_en_a: assert property (w_c |-> ##2 analog_ctrl.loop_enable == $past(cfg_req.wdata[7], 2))
    else $error("loop enable wrong");
  auto_go_a: assert property (w_c && cfg_req.wdata == auto_cal_cmd |=> cal_busy)
    else $error("search not started");
  busy_end_a: assert property ($rose(cal_busy) |-> ##[1:400] !cal_busy)
    else $error("search too long");
  man_band_a: assert property (w_c && cfg_req.wdata[6] |-> ##2 analog_ctrl.band == $past(cfg_req.wdata[5:0], 2))
    else $error("manual band wrong");
  loop_set_a: assert property (cfg_req.wr && cfg_req.addr == pll_loop_settings_addr |->
    ##2 {analog_ctrl.loop_bw, analog_ctrl.cp_current} == $past(cfg_req.wdata, 2))
    else $error("loop settings wrong");
  cross_en_a: assert property (cfg_req.wr && cfg_req.addr == pll_cross_control_addr |->
    ##2 analog_ctrl.cross_enable == $past(cfg_req.wdata[4], 2))
    else $error("cross enable wrong");
  clk_corr_a: assert property (cfg_req.wr && cfg_req.addr == clock_config_addr |->
    ##2 {analog_ctrl.duty_correct, analog_ctrl.level_correct} == $past(cfg_req.wdata[7:6], 2))
    else $error("correction bits wrong");
  vt_read_a: assert property (cfg_req.rd && cfg_req.addr == vco_tuning_voltage_addr
    && $past({lock_in, vtune_code_in}, 3) == {lock_in, vtune_code_in}
    |=> {cfg_rdata[7], cfg_rdata[3:0]} == $past({lock_in, vtune_code_in}))
    else $error("voltage readback wrong");
  // Main scenarios
  cover property ($fell(cal_busy));
  cover property (w_c && cfg_req.wdata[6]);
  cover property (cfg_req.rd && cfg_req.addr == vco_tuning_voltage_addr);
endmodule

// file: sim/analog_side_model.sv
// Far-side model: oscillator voltage code and lock
`timescale 1ns/1ns
module analog_side_model
  import clk_ctrl_pkg::*;
(
  input  wire analog_ctrl_t ctrl,  // Controls from the block
  output logic [3:0]        vtune, // Voltage code
  output logic              lock   // Loop lock
);
  // Bands below 3 ask higher, band 3 mid-range, above ask lower
  always_comb begin
    vtune = ctrl.band < 6'h03 ? 4'hf : ctrl.band == 6'h03 ? 4'h8 : 4'h0;
    lock = ctrl.loop_enable;
  end
endmodule

// file: sim/dac_clock_pll_control_tb_top.sv
// Testbench for the sample-clock control block
`timescale 1ns/1ns
module dac_clock_pll_control_tb_top;
  import clk_ctrl_pkg::*;
  localparam int settle_count = 4;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  cfg_req_t     req = '0;
  logic [7:0]   rdata;
  logic         rvalid;
  logic         lock;
  logic         busy;
  logic [3:0]   vtune;
  analog_ctrl_t actl;
  logic [7:0]   got;
  logic [7:0]   addrs [5] = '{8'h08, 8'h0a, 8'h0c, 8'h0d, 8'h33};
  int           errors = 0;
  int           n_tests = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  clock_source_ctrl #(.settle_count(settle_count)) dut_u (.clk(clk), .rst(rst), .cfg_req(req),
    .cfg_rdata(rdata), .cfg_rvalid(rvalid), .vtune_code_in(vtune), .lock_in(lock),
    .analog_ctrl(actl), .cal_busy(busy));
  analog_side_model far_u (.ctrl(actl), .vtune(vtune), .lock(lock));
  // Compare and count
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  // Read; valid pulse checked in its cycle, data left in got
  task rd(input logic [7:0] a);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    got = rdata;
  endtask
  task finish_test();
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  // Test sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk({7'h00, actl.use_direct_clock}, 8'h01);
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chk(got, 8'h00);
    end
    $display("test reset done");
    wr(pll_loop_settings_addr, 8'hd1);
    wr(pll_cross_control_addr, 8'h10);
    wr(clock_config_addr, 8'hc0);
    wr(vco_tuning_voltage_addr, 8'h00);
    rd(pll_loop_settings_addr);
    chk(got, 8'hd1);
    chk({actl.loop_bw, actl.cp_current}, 8'hd1);
    chk({actl.cross_enable, actl.duty_correct, actl.level_correct, 5'h00}, 8'he0);
    $display("test settings done");
    for (int b = 0; b < 6; b++) begin
      wr(pll_control_addr, 8'hc0 | 8'(b));
      repeat (6) @(negedge clk);
      rd(vco_tuning_voltage_addr);
      chk({3'h0, got[7], got[3:0]}, {4'h1, b < 3 ? 4'hf : b == 3 ? 4'h8 : 4'h0});
      chk({2'h0, actl.band}, 8'(b));
    end
    $display("test manual done");
    wr(pll_control_addr, 8'h03);
    repeat (2) @(negedge clk);
    chk({6'h00, actl.loop_enable, actl.use_direct_clock}, 8'h01);
    wr(pll_control_addr, auto_cal_cmd);
    chk({7'h00, busy}, 8'h01);
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(negedge clk);
    chk({2'h0, actl.band}, 8'h03);
    repeat (4) @(negedge clk);
    rd(vco_tuning_voltage_addr);
    chk(got, 8'hf8);
    $display("test auto done");
    finish_test();
  end
endmodule

bind clock_source_ctrl clock_source_ctrl_sva #(.settle_count(settle_count)) sva_u (.clk(clk), .rst(rst),
  .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .vtune_code_in(vtune_code_in),
  .lock_in(lock_in), .analog_ctrl(analog_ctrl), .cal_busy(cal_busy));
